/* rtl/rcda_align.sv */
`timescale 1ns/1ps
`include "rcda_defines.svh"

// Functional notes
// - Detection enabled searches for commas and framing.
// - Valid-comma-only restricts matches to exact characters.
// - Configurable ten-bit plus comma pattern.
// - Configurable ten-bit minus comma pattern.
// - Pattern bit zero is the earliest bit.
// - Mask one compares bit, zero ignores it.
// - Any-byte mode moves comma to byte boundary.
// - Two-byte mode moves comma to pair boundary.
// - Four-byte mode moves comma to word boundary.
// - Plus comma realigns only with plus enable.
// - Minus comma realigns only with minus enable.
// - Each slip assertion shifts alignment one bit.
// - Slip wins over comma-based realignment.
// - Aligned flag high while data is aligned.
// - Realigned flag marks comma-driven alignment change.
// - Comma-seen flag marks every detected comma.
module rcda_align (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Deserialized line words, bit zero received first.
  input wire logic [`RCDA_WORD_W-1:0] lineData,
  // Detection configuration.
  input wire logic commaDetectEnable,
  input wire logic validCommaOnly,
  input wire rcda_pkg::rcda_grid_t alignGrid,
  input wire logic [`RCDA_CHAR_W-1:0] plusCommaPattern,
  input wire logic [`RCDA_CHAR_W-1:0] minusCommaPattern,
  input wire logic [`RCDA_CHAR_W-1:0] commaMask,
  // User alignment controls.
  input wire logic plusAlignEnable,
  input wire logic minusAlignEnable,
  input wire logic bitSlipRequest,
  // Aligned data and status.
  output logic [`RCDA_WORD_W-1:0] rxData,
  output logic wordAlignedFlag,
  output logic alignmentChangedFlag,
  output logic commaSeenFlag
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Reduces a bit position to the grid in force, so that two positions
  // with equal results put a comma on the same kind of boundary.
  function automatic logic [`RCDA_OFS_W-1:0] gridOffset(
    input logic [`RCDA_OFS_W-1:0] p,
    input rcda_pkg::rcda_grid_t g
  );
    case (g)
      rcda_pkg::RCDA_ANY_BYTE: return p % `RCDA_GRID_ONE;
      rcda_pkg::RCDA_TWO_BYTE: return p % `RCDA_GRID_TWO;
      rcda_pkg::RCDA_FOUR_BYTE: return p;
      default: return p;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [`RCDA_WORD_W-1:0] prevR;
  logic [`RCDA_HIST_W-1:0] hist;
  logic [`RCDA_HIST_W-1:0] shifted;
  logic [`RCDA_WORD_W-1:0] window;
  logic [`RCDA_OFS_W-1:0] ofsR;
  logic [`RCDA_OFS_W-1:0] ofsNxt;
  logic slipLevelR;
  logic slipEdge;
  logic plusHit;
  logic minusHit;
  logic [`RCDA_OFS_W-1:0] plusPos;
  logic [`RCDA_OFS_W-1:0] minusPos;
  logic plusSeen;
  logic minusSeen;
  logic commaAny;
  logic usePlus;
  logic useMinus;
  logic alignReq;
  logic [`RCDA_OFS_W-1:0] hitPos;
  logic [`RCDA_OFS_W-1:0] seenPos;
  logic [`RCDA_OFS_W-1:0] targetOfs;
  logic [`RCDA_OFS_W-1:0] slipOfs;
  logic changeOfs;
  logic onGrid;
  rcda_pkg::rcda_state_t stateR;
  rcda_pkg::rcda_state_t stateNxt;

  // ----------------------------------------------------------------------
  // History window
  // ----------------------------------------------------------------------
  // The older word sits in the low half, so bit zero of the history is
  // the earliest bit on the line, matching the pattern convention.
  assign hist = {lineData, prevR};

  // The output word starts ofsR bits into the history.
  assign shifted = hist >> ofsR;
  assign window = shifted[`RCDA_WORD_W-1:0];

  // Keeps the previous line word for the history.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prevR <= `RCDA_WORD_RST;
    end else begin
      prevR <= lineData;
    end
  end

  // ----------------------------------------------------------------------
  // Comma search
  // ----------------------------------------------------------------------
  // Plus comma scanner, held pattern taken from the configuration port.
  rcda_comma_scan plusScan (
    .hist(hist),
    .pattern(plusCommaPattern),
    .mask(commaMask),
    .exactOnly(validCommaOnly),
    .hit(plusHit),
    .pos(plusPos)
  );

  // Minus comma scanner.
  rcda_comma_scan minusScan (
    .hist(hist),
    .pattern(minusCommaPattern),
    .mask(commaMask),
    .exactOnly(validCommaOnly),
    .hit(minusHit),
    .pos(minusPos)
  );

  // Hits count only while detection is on; the patterns are free, so
  // framing characters are caught just like commas.
  assign plusSeen = commaDetectEnable & plusHit;
  assign minusSeen = commaDetectEnable & minusHit;
  assign commaAny = plusSeen | minusSeen;
  assign seenPos = plusSeen ? plusPos : minusPos;

  // ----------------------------------------------------------------------
  // Realignment decision
  // ----------------------------------------------------------------------
  // Each comma polarity may move the boundary only under its enable.
  assign usePlus = plusSeen & plusAlignEnable;
  assign useMinus = minusSeen & minusAlignEnable;
  assign alignReq = usePlus | useMinus;
  assign hitPos = usePlus ? plusPos : minusPos;

  // New offset puts the comma on the boundary grid selected.
  assign targetOfs = gridOffset(hitPos, alignGrid);
  assign changeOfs = targetOfs != ofsR;
  assign onGrid = gridOffset(seenPos, alignGrid)
                  == gridOffset(ofsR, alignGrid);

  // A slip is taken on the rising edge, so one assertion is one step.
  assign slipEdge = bitSlipRequest & ~slipLevelR;
  assign slipOfs = (ofsR == `RCDA_OFS_LAST) ? `RCDA_OFS_RST
                                            : ofsR + 6'h01;

  // Slip comes before any comma realignment in the same cycle.
  assign ofsNxt = slipEdge ? slipOfs
                : alignReq ? targetOfs
                : ofsR;

  // ----------------------------------------------------------------------
  // Alignment state machine
  // ----------------------------------------------------------------------
  // Hunt until a comma or slip sets the boundary, shift for the cycle
  // in which a comma moved it, then lock; an off-grid comma that may
  // not realign drops back to hunt.
  always_comb begin
    stateNxt = stateR;
    case (stateR)
      rcda_pkg::RCDA_HUNT: begin
        if (slipEdge) begin
          stateNxt = rcda_pkg::RCDA_LOCK;
        end else if (alignReq) begin
          stateNxt = changeOfs ? rcda_pkg::RCDA_SHIFT : rcda_pkg::RCDA_LOCK;
        end
      end
      rcda_pkg::RCDA_SHIFT, rcda_pkg::RCDA_LOCK: begin
        if (slipEdge) begin
          stateNxt = rcda_pkg::RCDA_LOCK;
        end else if (alignReq) begin
          stateNxt = changeOfs ? rcda_pkg::RCDA_SHIFT : rcda_pkg::RCDA_LOCK;
        end else if (commaAny && !onGrid) begin
          stateNxt = rcda_pkg::RCDA_HUNT;
        end else begin
          stateNxt = rcda_pkg::RCDA_LOCK;
        end
      end
      default: begin
        stateNxt = rcda_pkg::RCDA_HUNT;
      end
    endcase
  end

  // State, offset and slip level registers.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stateR <= rcda_pkg::RCDA_HUNT;
      ofsR <= `RCDA_OFS_RST;
      slipLevelR <= 1'b0;
    end else begin
      stateR <= stateNxt;
      ofsR <= ofsNxt;
      slipLevelR <= bitSlipRequest;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Data and flags are registered; the realigned flag tells the user
  // that the word boundary just moved and nearby data may be damaged.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rxData <= `RCDA_WORD_RST;
      wordAlignedFlag <= 1'b0;
      alignmentChangedFlag <= 1'b0;
      commaSeenFlag <= 1'b0;
    end else begin
      rxData <= window;
      wordAlignedFlag <= stateNxt != rcda_pkg::RCDA_HUNT;
      alignmentChangedFlag <= stateNxt == rcda_pkg::RCDA_SHIFT;
      commaSeenFlag <= commaAny;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // A comma that realigns the boundary without a competing slip.
  sequence commaMove;
    alignReq && !slipEdge && changeOfs;
  endsequence

  // The flags that follow such a move.
  sequence moveFlags;
    alignmentChangedFlag && wordAlignedFlag;
  endsequence

  // A lone slip edge, away from the wrap point.
  sequence slipStep;
    slipEdge && ofsR != `RCDA_OFS_LAST;
  endsequence

  detectGate_a: assert property (
    commaSeenFlag |-> $past(commaDetectEnable)
  ) else $error("comma flag without detection enabled");

  exactMatch_a: assert property (
    plusSeen && validCommaOnly |-> hist[plusPos +: `RCDA_CHAR_W] ==
      plusCommaPattern
  ) else $error("inexact plus comma accepted");

  maskMatch_a: assert property (
    minusSeen |-> ((hist[minusPos +: `RCDA_CHAR_W] ^ minusCommaPattern) &
      commaMask) == `RCDA_MASK_ZERO
  ) else $error("minus comma matched outside mask");

  anyByteGrid_a: assert property (
    alignReq && !slipEdge && alignGrid == rcda_pkg::RCDA_ANY_BYTE |=>
      ofsR == $past(hitPos) % `RCDA_GRID_ONE
  ) else $error("any byte realign offset wrong");

  twoByteGrid_a: assert property (
    alignReq && !slipEdge && alignGrid == rcda_pkg::RCDA_TWO_BYTE |=>
      ofsR == $past(hitPos) % `RCDA_GRID_TWO
  ) else $error("two byte realign offset wrong");

  fourByteGrid_a: assert property (
    alignReq && !slipEdge && alignGrid == rcda_pkg::RCDA_FOUR_BYTE |=>
      ofsR == $past(hitPos)
  ) else $error("four byte realign offset wrong");

  plusHold_a: assert property (
    plusSeen && !plusAlignEnable && !useMinus && !slipEdge |=> $stable(ofsR)
  ) else $error("plus comma moved boundary while disabled");

  minusHold_a: assert property (
    minusSeen && !minusAlignEnable && !usePlus && !slipEdge |=> $stable(ofsR)
  ) else $error("minus comma moved boundary while disabled");

  slipOneBit_a: assert property (
    slipStep |=> ofsR == $past(ofsR) + 6'h01 ##1
      ofsR == $past(ofsR) || $past(alignReq)
  ) else $error("slip did not move exactly one bit");

  slipFirst_a: assert property (
    slipEdge && alignReq |=> !alignmentChangedFlag && wordAlignedFlag
  ) else $error("comma realign beat slip request");

  offGridDrop_a: assert property (
    commaAny && !onGrid && !alignReq && !slipEdge |=> !wordAlignedFlag
  ) else $error("aligned flag kept on misaligned comma");

  realignFlag_a: assert property (
    commaMove |=> moveFlags ##1
      !alignmentChangedFlag || $past(alignReq && !slipEdge && changeOfs)
  ) else $error("realigned flag not a pulse after move");

  seenFlag_a: assert property (
    commaAny |=> commaSeenFlag
  ) else $error("comma seen flag missed");

  stayUnaligned_a: assert property (
    !wordAlignedFlag && !slipEdge && !alignReq |=> !wordAlignedFlag
  ) else $error("aligned flag rose with no alignment");

  // Reverse checks that each flag has a cause, then slip wrap, hold with both enables low and plus mask match.
  alignRise_a: assert property (
    $rose(wordAlignedFlag) |-> $past(slipEdge || alignReq)
  ) else $error("aligned flag rose with no cause");

  changeCause_a: assert property (
    alignmentChangedFlag |-> $past(alignReq && changeOfs && !slipEdge)
  ) else $error("realigned flag with no comma move");

  seenCause_a: assert property (
    commaSeenFlag |-> $past(commaAny)
  ) else $error("comma flag with no comma");

  slipWrap_a: assert property (
    slipEdge && ofsR == `RCDA_OFS_LAST |=> ofsR == `RCDA_OFS_RST
  ) else $error("slip did not wrap the offset");

  bothOff_a: assert property (
    !plusAlignEnable && !minusAlignEnable && !slipEdge |=> $stable(ofsR)
  ) else $error("boundary moved with both enables low");

  plusMask_a: assert property (
    plusSeen && !validCommaOnly |-> ((hist[plusPos +: `RCDA_CHAR_W] ^
      plusCommaPattern) & commaMask) == `RCDA_MASK_ZERO
  ) else $error("plus comma matched outside mask");

endmodule // rcda_align

/* rtl/rcda_defines.svh */
`ifndef RCDA_DEFINES_SVH
`define RCDA_DEFINES_SVH

// ----------------------------------------------------------------------
// Datapath geometry
// ----------------------------------------------------------------------
// One line character is ten bits; a parallel word carries four of them.
`define RCDA_CHAR_W 10
`define RCDA_WORD_W 40
`define RCDA_HIST_W 80
`define RCDA_OFS_W 6

// Offset grids in bits: one character, two characters, last offset.
`define RCDA_GRID_ONE 6'h0a
`define RCDA_GRID_TWO 6'h14
`define RCDA_OFS_LAST 6'h27
`define RCDA_OFS_RST 6'h00

// ----------------------------------------------------------------------
// Reference comma values
// ----------------------------------------------------------------------
// Plus and minus K28.5 patterns and a mask comparing the low seven bits.
`define RCDA_PLUS_K285 10'h17c
`define RCDA_MINUS_K285 10'h283
`define RCDA_MASK_LOW7 10'h07f
`define RCDA_MASK_ZERO 10'h000
`define RCDA_WORD_RST 40'h00_0000_0000

`endif

/* rtl/rcda_pkg.sv */
// ----------------------------------------------------------------------
// Types shared by the comma aligner
// ----------------------------------------------------------------------
package rcda_pkg;

  // Boundary grid that a detected comma is moved onto.
  typedef enum logic [1:0] {
    RCDA_ANY_BYTE = 2'h0,
    RCDA_TWO_BYTE = 2'h1,
    RCDA_FOUR_BYTE = 2'h3
  } rcda_grid_t;

  // Alignment state; hunt, shift and lock follow a Gray sequence.
  typedef enum logic [1:0] {
    RCDA_HUNT = 2'h0,
    RCDA_SHIFT = 2'h1,
    RCDA_LOCK = 2'h3
  } rcda_state_t;

endpackage

/* rtl/rcda_comma_scan.sv */
`timescale 1ns/1ps
`include "rcda_defines.svh"

// Searches the two-word history for one masked comma pattern and
// reports the lowest, that is earliest, bit position where it matches.
module rcda_comma_scan (
  // History and pattern.
  input wire logic [`RCDA_HIST_W-1:0] hist,
  input wire logic [`RCDA_CHAR_W-1:0] pattern,
  input wire logic [`RCDA_CHAR_W-1:0] mask,
  input wire logic exactOnly,
  // Result.
  output logic hit,
  output logic [`RCDA_OFS_W-1:0] pos
);

  // ----------------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------------
  // A mask bit of one makes the pattern bit count; zero is don't-care.
  // Exact mode ignores the mask and takes only the full character.
  function automatic logic maskedEq(
    input logic [`RCDA_CHAR_W-1:0] seg,
    input logic [`RCDA_CHAR_W-1:0] pat,
    input logic [`RCDA_CHAR_W-1:0] msk,
    input logic exact
  );
    logic [`RCDA_CHAR_W-1:0] diff;
    diff = seg ^ pat;
    if (exact) begin
      return diff == `RCDA_MASK_ZERO;
    end
    return (diff & msk) == `RCDA_MASK_ZERO;
  endfunction

  // ----------------------------------------------------------------------
  // Priority search
  // ----------------------------------------------------------------------
  // Scanning downward leaves the lowest matching position in pos.
  always_comb begin
    hit = 1'b0;
    pos = `RCDA_OFS_RST;
    for (int i = `RCDA_WORD_W - 1; i >= 0; i--) begin
      if (maskedEq(hist[i +: `RCDA_CHAR_W], pattern, mask, exactOnly)) begin
        hit = 1'b1;
        pos = `RCDA_OFS_W'(i);
      end
    end
  end

endmodule // rcda_comma_scan

/* verif/rcda_line_src.sv */
`timescale 1ns/1ps
`include "rcda_defines.svh"

// ----------------------------------------------------------------------
// Deserializer stand-in
// ----------------------------------------------------------------------
// Builds one parallel word from a fill pattern with one character placed
// at a bit position. Bit zero is the earliest bit on the line.
module rcda_line_src (
  // Word content.
  input wire logic [`RCDA_WORD_W-1:0] fill,
  input wire logic [`RCDA_CHAR_W-1:0] commaChar,
  input wire logic [5:0] commaPos,
  input wire logic commaOn,
  // Deserialized word.
  output logic [`RCDA_WORD_W-1:0] lineData
);
  logic [`RCDA_HIST_W-1:0] charAt;
  logic [`RCDA_HIST_W-1:0] holeAt;

  // A character past bit 39 wraps into the low bits of the same word.
  // A repeated word then makes a comma that straddles two words.
  assign charAt = {70'h0, commaChar} << commaPos;
  assign holeAt = {70'h0, 10'h3ff} << commaPos;
  assign lineData = commaOn ?
    ((fill & ~(holeAt[79:40] | holeAt[39:0])) | charAt[79:40] | charAt[39:0])
    : fill;
endmodule // rcda_line_src

/* verif/rcda_align_tb_top.sv */
`timescale 1ns/1ps
`include "rcda_defines.svh"

module rcda_align_tb_top;
  // ----------------------------------------------------------------------
  // Stimulus and outputs
  // ----------------------------------------------------------------------
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [`RCDA_WORD_W-1:0] fill = {4{10'h155}};
  logic [`RCDA_CHAR_W-1:0] commaChar = `RCDA_PLUS_K285;
  logic [5:0] commaPos = 6'h00;
  logic commaOn = 1'b0;
  logic commaDetectEnable = 1'b1;
  logic validCommaOnly = 1'b0;
  rcda_pkg::rcda_grid_t alignGrid = rcda_pkg::RCDA_ANY_BYTE;
  logic [9:0] plusCommaPattern = `RCDA_PLUS_K285;
  logic [9:0] minusCommaPattern = `RCDA_MINUS_K285;
  logic [9:0] commaMask = `RCDA_MASK_LOW7;
  logic plusAlignEnable = 1'b1;
  logic minusAlignEnable = 1'b1;
  logic bitSlipRequest = 1'b0;
  logic [39:0] lineData;
  logic [39:0] rxData;
  logic wordAlignedFlag;
  logic alignmentChangedFlag;
  logic commaSeenFlag;
  int errCount = 0;
  int nTests = 0;

  // The clock toggles every half period of 5 ns.
  always #5 mclk = ~mclk;

  rcda_line_src lineSrc (.fill(fill), .commaChar(commaChar),
    .commaPos(commaPos), .commaOn(commaOn), .lineData(lineData));

  rcda_align DUT (.mclk(mclk), .rstn(rstn), .lineData(lineData),
    .commaDetectEnable(commaDetectEnable), .validCommaOnly(validCommaOnly),
    .alignGrid(alignGrid), .plusCommaPattern(plusCommaPattern),
    .minusCommaPattern(minusCommaPattern), .commaMask(commaMask),
    .plusAlignEnable(plusAlignEnable), .minusAlignEnable(minusAlignEnable),
    .bitSlipRequest(bitSlipRequest), .rxData(rxData),
    .wordAlignedFlag(wordAlignedFlag),
    .alignmentChangedFlag(alignmentChangedFlag),
    .commaSeenFlag(commaSeenFlag));

  // ----------------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------------
  logic [79:0] h;
  logic [39:0] prevLine = 40'h0;
  logic [39:0] expData = 40'h0;
  logic [5:0] ofs = 6'h00;
  logic [5:0] pPos, mPos, tgt;
  logic pHit, mHit, slip, pGo, mGo;
  logic prevSlip = 1'b0;
  logic expAligned = 1'b0;
  logic expChg = 1'b0;
  logic expSeen = 1'b0;
  int same = 0;

  // Lowest history position where the masked or exact pattern matches.
  function automatic logic [6:0] scan(input logic [79:0] hv,
      input logic [9:0] pat);
    for (int p = 0; p < 40; p++) begin
      if (validCommaOnly ? (hv[p +: 10] == pat)
          : (((hv[p +: 10] ^ pat) & commaMask) == 10'h000))
        return {1'b1, 6'(p)};
    end
    return 7'h00;
  endfunction

  // Reduces a bit position onto the selected boundary grid.
  function automatic logic [5:0] onGrid(input logic [5:0] p,
      input rcda_pkg::rcda_grid_t g);
    case (g)
      rcda_pkg::RCDA_ANY_BYTE: return p % 6'h0a;
      rcda_pkg::RCDA_TWO_BYTE: return p % 6'h14;
      default: return p;
    endcase
  endfunction

  // Predicts the outputs that the design presents after each edge.
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prevLine = 40'h0;
      ofs = 6'h00;
      prevSlip = 1'b0;
      same = 0;
      expData = 40'h0;
      expAligned = 1'b0;
      expChg = 1'b0;
      expSeen = 1'b0;
    end else begin
      h = {lineData, prevLine};
      {pHit, pPos} = scan(h, plusCommaPattern);
      {mHit, mPos} = scan(h, minusCommaPattern);
      pHit = pHit & commaDetectEnable;
      mHit = mHit & commaDetectEnable;
      pGo = pHit & plusAlignEnable;
      mGo = mHit & minusAlignEnable;
      slip = bitSlipRequest & ~prevSlip;
      same = (lineData === prevLine) ? same + 1 : 0;
      expData = h[ofs +: 40];
      expSeen = pHit | mHit;
      expChg = 1'b0;
      if (slip) begin
        ofs = (ofs == `RCDA_OFS_LAST) ? 6'h00 : ofs + 6'h01;
        expAligned = 1'b1;
      end else if (pGo | mGo) begin
        tgt = onGrid(pGo ? pPos : mPos, alignGrid);
        expChg = (tgt != ofs);
        ofs = tgt;
        expAligned = 1'b1;
      end else if (expSeen && onGrid(pHit ? pPos : mPos, alignGrid)
                   != onGrid(ofs, alignGrid)) begin
        // The plus comma stands for the cycle when both polarities hit.
        expAligned = 1'b0;
      end
      prevLine = lineData;
      prevSlip = bitSlipRequest;
    end
  end

  // ----------------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [39:0] exp,
      input logic [39:0] got);
    nTests++;
    if (exp !== got) begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finishTest();
    $display("Comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Compares at each falling edge, before new inputs are applied.
  task automatic cyc(input int n);
    repeat (n) begin
      @(negedge mclk);
      check("changed", {39'h0, expChg}, {39'h0, alignmentChangedFlag});
      check("seen", {39'h0, expSeen}, {39'h0, commaSeenFlag});
      check("aligned", {39'h0, expAligned}, {39'h0, wordAlignedFlag});
      // Data beside a boundary move is only judged once the line is steady.
      if (same >= 2) check("rxData", expData, rxData);
    end
  endtask

  // Cuts a hung run short.
  initial begin
    #200000;
    errCount++;
    finishTest();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'h8dbd_bdee));
    cyc(4);
    rstn = 1'b1;
    cyc(6);
    // Every grid with plus and minus commas, some straddling words.
    for (int g = 0; g < 4; g++) begin
      for (int c = 0; c < 2; c++) begin
        alignGrid = rcda_pkg::rcda_grid_t'(2'(g));
        commaChar = c ? `RCDA_MINUS_K285 : `RCDA_PLUS_K285;
        commaPos = 6'(13 + 8 * g + c);
        commaOn = 1'b1;
        cyc(4);
        commaOn = 1'b0;
        cyc(2);
      end
    end
    // Minus comma with enables off, then plus only, then minus.
    plusAlignEnable = 1'b0;
    minusAlignEnable = 1'b0;
    commaPos = 6'h05;
    commaOn = 1'b1;
    cyc(4);
    plusAlignEnable = 1'b1;
    cyc(3);
    minusAlignEnable = 1'b1;
    cyc(3);
    // Slip held high while an aligning comma is present: one slip only.
    commaPos = 6'h11;
    bitSlipRequest = 1'b1;
    cyc(5);
    bitSlipRequest = 1'b0;
    commaOn = 1'b0;
    plusAlignEnable = 1'b0;
    minusAlignEnable = 1'b0;
    fill = 40'h5a_c3e1_0f96;
    // Forty-one slips walk the offset through its wrap.
    for (int i = 0; i < 41; i++) begin
      cyc(1);
      bitSlipRequest = 1'b1;
      cyc(2);
      bitSlipRequest = 1'b0;
    end
    // Reset in mid-run drops the boundary and the aligned flag.
    rstn = 1'b0;
    cyc(2);
    rstn = 1'b1;
    cyc(3);
    // A comma differing in a masked bit: exact mode refuses it.
    plusAlignEnable = 1'b1;
    fill = {4{10'h155}};
    commaChar = `RCDA_PLUS_K285 ^ 10'h200;
    commaPos = 6'h09;
    commaOn = 1'b1;
    validCommaOnly = 1'b1;
    cyc(3);
    validCommaOnly = 1'b0;
    cyc(3);
    commaDetectEnable = 1'b0;
    cyc(3);
    // Random traffic with random controls.
    for (int i = 0; i < 800; i++) begin
      fill = 40'({$urandom, $urandom});
      commaChar = $urandom_range(0, 1) ? `RCDA_PLUS_K285 : `RCDA_MINUS_K285;
      commaPos = 6'($urandom_range(0, 39));
      commaOn = 1'($urandom);
      alignGrid = rcda_pkg::rcda_grid_t'(2'($urandom));
      plusAlignEnable = 1'($urandom);
      minusAlignEnable = 1'($urandom);
      bitSlipRequest = ($urandom_range(0, 7) == 0);
      validCommaOnly = ($urandom_range(0, 3) == 0);
      commaDetectEnable = ($urandom_range(0, 7) != 0);
      commaMask = ($urandom_range(0, 3) == 0) ? 10'($urandom)
                  : `RCDA_MASK_LOW7;
      cyc($urandom_range(1, 4));
    end
    finishTest();
  end
endmodule // rcda_align_tb_top
